/* File: core/blc_regs.sv */
// file: transmit queue and the link control register block
`timescale 1ns/1ns
module blc_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop, room_ff, nxt_room;

  // pointer and fill arithmetic; flush drops a push in the same cycle
  always_comb begin
    push = in_valid && in_ready && !flush;
    pop = out_valid && out_ready && !flush;
    nxt_wp = wp_ff + AW'(push);
    nxt_rp = rp_ff + AW'(pop);
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_cnt = '0;
    end
    // ready is worked out one cycle early so the refusal comes straight from a flop
    nxt_room = nxt_cnt != (AW+1)'(D);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
      room_ff <= 1'b1;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
      room_ff <= nxt_room;
    end
  end

  // storage needs no reset, the fill count guards it
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_ff] <= in_data;
    end
  end

  assign in_ready = room_ff;
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rp_ff];
  assign count = cnt_ff;
endmodule // blc_fifo

module blc_regs #(
  parameter int WDT_A = blc_pkg::WDT_A_CYC,
  parameter int WDT_B = blc_pkg::WDT_B_CYC,
  parameter int WDT_C = blc_pkg::WDT_C_CYC,
  parameter logic [15:0] ID_CODE = 16'h5A5A // arbitrary identity value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic link_clk_in,
  output logic link_clk_out,
  output logic link_data_out,
  input wire logic [15:0] tx_word,
  input wire logic tx_word_valid,
  output logic tx_word_ready,
  input wire logic rx_word_taken,
  output logic data_ready_pin_n,
  output logic safe_state
);
  localparam logic [3:0] PIN_RST = 4'h1; // chip select idles high
  localparam int P_CS = 0;
  localparam int P_SCK = 1;
  localparam int P_MOSI = 2;
  localparam int P_LCK = 3;

  // pin synchronisers: three stages, a change counts once stages two and three agree
  logic [3:0] pin_in, s1_ff, s2_ff, s3_ff, flt_ff, prv_ff, nxt_flt;
  assign pin_in = {link_clk_in, spi_mosi, spi_sclk, spi_cs_n};
  always_comb begin
    nxt_flt = (s3_ff & ~(s2_ff ^ s3_ff)) | (flt_ff & (s2_ff ^ s3_ff));
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_ff <= PIN_RST;
      s2_ff <= PIN_RST;
      s3_ff <= PIN_RST;
      flt_ff <= PIN_RST;
      prv_ff <= PIN_RST;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      flt_ff <= nxt_flt;
      prv_ff <= flt_ff;
    end
  end

  logic cs_n, sclk_rise, sclk_fall, cs_rise, lclk_rise;
  assign cs_n = flt_ff[P_CS];
  assign sclk_rise = flt_ff[P_SCK] && !prv_ff[P_SCK];
  assign sclk_fall = !flt_ff[P_SCK] && prv_ff[P_SCK];
  assign cs_rise = flt_ff[P_CS] && !prv_ff[P_CS];
  assign lclk_rise = flt_ff[P_LCK] && !prv_ff[P_LCK];

  blc_pkg::blc_cfg_t cfg_ff, nxt_cfg;
  blc_pkg::blc_state_t state_ff, nxt_state;

  // serial port: 8 header bits (write flag, 7-bit index) then 16 data bits, msb first
  logic [4:0] bcnt_ff, nxt_bcnt;
  logic [23:0] sh_ff, nxt_sh, frame_in;
  logic [15:0] rd_ff, nxt_rd, rdata, wd_ff, nxt_wd;
  logic [6:0] wa_ff, nxt_wa;
  logic sdo_ff, nxt_sdo, oe_ff, wr_ff, nxt_wr;

  // read decode of the index just received
  always_comb begin
    rdata = 16'h0000;
    if (frame_in[6:0] == blc_pkg::ADR_ID) begin
      rdata = ID_CODE;
    end else if (frame_in[6:0] == blc_pkg::ADR_HOST) begin
      rdata[blc_pkg::WDT_LSB +: 2] = cfg_ff.wdt;
    end else if (frame_in[6:0] == blc_pkg::ADR_RATE) begin
      rdata[blc_pkg::RATE_LSB +: 4] = cfg_ff.rate;
      rdata[blc_pkg::SPREAD_LSB +: 2] = cfg_ff.spread;
    end else if (frame_in[6:0] == blc_pkg::ADR_TXL) begin
      rdata[blc_pkg::TXL_LSB +: 9] = cfg_ff.tx_lvl; // flush bit reads zero
    end else if (frame_in[6:0] == blc_pkg::ADR_RXL) begin
      rdata[blc_pkg::RXL_LSB +: 8] = cfg_ff.rx_lvl;
    end
  end

  always_comb begin
    frame_in = {sh_ff[22:0], flt_ff[P_MOSI]};
    nxt_bcnt = bcnt_ff;
    nxt_sh = sh_ff;
    nxt_rd = rd_ff;
    nxt_sdo = sdo_ff;
    nxt_wr = 1'b0;
    nxt_wa = wa_ff;
    nxt_wd = wd_ff;
    if (cs_n) begin
      nxt_bcnt = 5'h00;
    end else if (sclk_rise) begin
      nxt_sh = frame_in;
      if (bcnt_ff != 5'(blc_pkg::FRAME_LAST + 1)) begin
        nxt_bcnt = bcnt_ff + 5'h01; // bits past the frame are ignored
      end
      if (bcnt_ff == 5'(blc_pkg::HDR_LAST)) begin
        nxt_sdo = rdata[15];
        nxt_rd = {rdata[14:0], 1'b0};
      end
      if (bcnt_ff == 5'(blc_pkg::FRAME_LAST)) begin
        nxt_wr = frame_in[23];
        nxt_wa = frame_in[22:16];
        nxt_wd = frame_in[15:0];
      end
    end else if (sclk_fall && bcnt_ff > 5'(blc_pkg::HDR_LAST + 1)) begin
      nxt_sdo = rd_ff[15];
      nxt_rd = {rd_ff[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bcnt_ff <= 5'h00;
      sh_ff <= 24'h000000;
      rd_ff <= 16'h0000;
      sdo_ff <= 1'b0;
      oe_ff <= 1'b0;
      wr_ff <= 1'b0;
      wa_ff <= 7'h00;
      wd_ff <= 16'h0000;
    end else begin
      bcnt_ff <= nxt_bcnt;
      sh_ff <= nxt_sh;
      rd_ff <= nxt_rd;
      sdo_ff <= nxt_sdo;
      oe_ff <= !cs_n;
      wr_ff <= nxt_wr;
      wa_ff <= nxt_wa;
      wd_ff <= nxt_wd;
    end
  end

  // register writes; action bits become single pulses and are never stored
  logic enter_ff, nxt_enter, leave_ff, nxt_leave, txf_ff, nxt_txf, rxf_ff, nxt_rxf, wexp_ff;
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_enter = 1'b0;
    nxt_leave = 1'b0;
    nxt_txf = 1'b0;
    nxt_rxf = 1'b0;
    nxt_state = state_ff;
    if (wr_ff) begin
      if (wa_ff == blc_pkg::ADR_HOST) begin
        nxt_cfg.wdt = wd_ff[blc_pkg::WDT_LSB +: 2];
      end else if (wa_ff == blc_pkg::ADR_RATE) begin
        nxt_cfg.rate = wd_ff[blc_pkg::RATE_LSB +: 4];
        nxt_cfg.spread = wd_ff[blc_pkg::SPREAD_LSB +: 2];
      end else if (wa_ff == blc_pkg::ADR_TXL) begin
        nxt_cfg.tx_lvl = wd_ff[blc_pkg::TXL_LSB +: 9];
        nxt_txf = wd_ff[blc_pkg::FLUSH_BIT];
      end else if (wa_ff == blc_pkg::ADR_RXL) begin
        nxt_cfg.rx_lvl = wd_ff[blc_pkg::RXL_LSB +: 8];
        nxt_rxf = wd_ff[blc_pkg::FLUSH_BIT];
      end else if (wa_ff == blc_pkg::ADR_SAFE) begin
        nxt_enter = wd_ff[blc_pkg::ENTER_BIT];
        nxt_leave = wd_ff[blc_pkg::LEAVE_BIT];
      end
    end
    // entering wins over leaving so a fault path is never masked
    if (enter_ff || wexp_ff) begin
      nxt_state = blc_pkg::ST_SAFE;
    end else if (leave_ff) begin
      nxt_state = blc_pkg::ST_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ff <= '{blc_pkg::RST_WDT, blc_pkg::RST_SPREAD, blc_pkg::RST_RATE, blc_pkg::RST_TXL, blc_pkg::RST_RXL};
      enter_ff <= 1'b0;
      leave_ff <= 1'b0;
      txf_ff <= 1'b0;
      rxf_ff <= 1'b0;
      state_ff <= blc_pkg::ST_NORMAL;
    end else begin
      cfg_ff <= nxt_cfg;
      enter_ff <= nxt_enter;
      leave_ff <= nxt_leave;
      txf_ff <= nxt_txf;
      rxf_ff <= nxt_rxf;
      state_ff <= nxt_state;
    end
  end

  // host inactivity watchdog, restarted by every end of frame
  logic [22:0] wdt_ff, nxt_wdt, wlim;
  logic nxt_wexp;
  always_comb begin
    case (cfg_ff.wdt)
      2'h0: wlim = 23'(WDT_A);
      2'h1: wlim = 23'(WDT_B);
      2'h2: wlim = 23'(WDT_C);
      default: wlim = 23'h000000; // disabled
    endcase
    nxt_wdt = wdt_ff;
    nxt_wexp = 1'b0;
    if (cs_rise || wlim == 23'h000000) begin
      nxt_wdt = 23'h000000;
    end else if (wdt_ff < wlim) begin
      nxt_wdt = wdt_ff + 23'h000001;
      nxt_wexp = nxt_wdt == wlim; // fires once, then holds
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_ff <= 23'h000000;
      wexp_ff <= 1'b0;
    end else begin
      wdt_ff <= nxt_wdt;
      wexp_ff <= nxt_wexp;
    end
  end

  // transmit queue
  logic [15:0] q_data;
  logic q_valid, q_pop;
  logic [5:0] q_count;
  blc_fifo #(.W(blc_pkg::WORD_W), .D(blc_pkg::TX_DEPTH)) u_txq (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(txf_ff),
    .in_data(tx_word),
    .in_valid(tx_word_valid),
    .in_ready(tx_word_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .count(q_count)
  );

  // link bit timer with spread: each period is stretched by a pseudo-random share
  logic [7:0] div_ff, nxt_div, lfsr_ff, nxt_lfsr, per, jit, plen;
  logic [15:0] ser_ff, nxt_ser;
  logic [3:0] left_ff, nxt_left;
  logic tick, lck_ff, nxt_lck, txd_ff, nxt_txd, start_ff, nxt_start;
  always_comb begin
    per = blc_pkg::rate_cycles(cfg_ff.rate);
    jit = 8'((int'(per) * blc_pkg::SPREAD_PCT[cfg_ff.spread] * int'(lfsr_ff[3:0])) / 1600);
    plen = per + jit;
    tick = div_ff >= plen - 8'h01;
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_lck = nxt_div < (plen >> 1);
    nxt_lfsr = tick ? {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]} : lfsr_ff;
    // hold words until the fill reaches the level plus one, run until drained
    nxt_start = start_ff ? (q_valid || left_ff != 4'h0) : ({3'b000, q_count} > cfg_ff.tx_lvl);
    q_pop = tick && left_ff == 4'h0 && q_valid && start_ff && state_ff == blc_pkg::ST_NORMAL;
    nxt_ser = ser_ff;
    nxt_left = left_ff;
    nxt_txd = txd_ff;
    if (tick) begin
      if (left_ff != 4'h0) begin
        nxt_txd = ser_ff[15];
        nxt_ser = {ser_ff[14:0], 1'b0};
        nxt_left = left_ff - 4'h1;
      end else if (q_pop) begin
        nxt_txd = q_data[15];
        nxt_ser = {q_data[14:0], 1'b0};
        nxt_left = 4'hF;
      end else begin
        nxt_txd = 1'b0;
      end
    end
    if (txf_ff) begin
      nxt_start = 1'b0; // a word in flight is dropped too
      nxt_left = 4'h0;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_ff <= 8'h00;
      lfsr_ff <= 8'h01;
      lck_ff <= 1'b0;
      ser_ff <= 16'h0000;
      left_ff <= 4'h0;
      txd_ff <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      lfsr_ff <= nxt_lfsr;
      lck_ff <= nxt_lck;
      ser_ff <= nxt_ser;
      left_ff <= nxt_left;
      txd_ff <= nxt_txd;
      start_ff <= nxt_start;
    end
  end

  // receive side: 16 returned link clock edges make one word
  logic [3:0] rbit_ff, nxt_rbit;
  logic [8:0] rx_ff, nxt_rx;
  logic data_ready_pin_n_ff, nxt_data_ready_pin_n;
  always_comb begin
    nxt_rbit = lclk_rise ? rbit_ff + 4'h1 : rbit_ff;
    nxt_rx = rx_ff;
    if (lclk_rise && rbit_ff == 4'hF && rx_ff != 9'h1FF) begin
      nxt_rx = nxt_rx + 9'h001;
    end
    if (rx_word_taken && nxt_rx != 9'h000) begin
      nxt_rx = nxt_rx - 9'h001;
    end
    if (rxf_ff) begin
      nxt_rx = 9'h000;
      nxt_rbit = 4'h0;
    end
    nxt_data_ready_pin_n = !(nxt_rx > {1'b0, nxt_cfg.rx_lvl});
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rbit_ff <= 4'h0;
      rx_ff <= 9'h000;
      data_ready_pin_n_ff <= 1'b1;
    end else begin
      rbit_ff <= nxt_rbit;
      rx_ff <= nxt_rx;
      data_ready_pin_n_ff <= nxt_data_ready_pin_n;
    end
  end

  assign spi_sdo = sdo_ff;
  assign spi_sdo_oe = oe_ff;
  assign link_clk_out = lck_ff;
  assign link_data_out = txd_ff;
  assign data_ready_pin_n = data_ready_pin_n_ff;
  assign safe_state = state_ff == blc_pkg::ST_SAFE;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_spread_off_flat: assert property (cfg_ff.spread == 2'h0 |-> plen == per)
    else $error("jitter present with spread off");
  // a register write inside the period may legally change the rate, so such attempts are dropped
  a_rate_fast_len: assert property (disable iff (sys_rst || wr_ff)
    tick && cfg_ff.spread == 2'h0 && cfg_ff.rate == 4'hF |=> !tick [*5] ##1 tick)
    else $error("top rate period is not six cycles");
  a_rate_monotone: assert property (cfg_ff.rate == 4'hF
    || blc_pkg::rate_cycles(cfg_ff.rate) > blc_pkg::rate_cycles(cfg_ff.rate + 4'h1))
    else $error("rate table not monotonic");
  a_tx_start_lvl: assert property ($rose(start_ff) |-> $past({3'b000, q_count}) > $past(cfg_ff.tx_lvl))
    else $error("transmission started below level");
  a_tx_flush_empty: assert property (txf_ff |=> q_count == 6'h00 && !start_ff)
    else $error("transmit flush left words");
  a_ready_pin_lvl: assert property (data_ready_pin_n == !(rx_ff > {1'b0, cfg_ff.rx_lvl}))
    else $error("data ready pin disagrees with receive fill");
  a_rx_flush_empty: assert property (rxf_ff |=> rx_ff == 9'h000)
    else $error("receive flush left words");
  a_enter_safe: assert property (wr_ff && wa_ff == blc_pkg::ADR_SAFE && wd_ff[blc_pkg::ENTER_BIT]
    |=> ##1 state_ff == blc_pkg::ST_SAFE)
    else $error("enter write did not reach safe state");
  a_leave_safe: assert property (leave_ff && !enter_ff && !wexp_ff |=> state_ff == blc_pkg::ST_NORMAL)
    else $error("leave write did not reach normal state");
  a_wdt_trip: assert property (wexp_ff |=> state_ff == blc_pkg::ST_SAFE)
    else $error("watchdog expiry ignored");
  a_action_once: assert property (enter_ff || leave_ff || txf_ff || rxf_ff
    |=> !(enter_ff || leave_ff || txf_ff || rxf_ff))
    else $error("action bit lasted beyond its write");
  c_safe_entry: cover property ($rose(state_ff == blc_pkg::ST_SAFE));
  c_tx_start: cover property ($rose(start_ff) ##[1:400] q_pop);
  c_ready_low: cover property ($fell(data_ready_pin_n));
endmodule // blc_regs

/* File: core/blc_pkg.sv */
// package: register map, field layout, reset values and timing for the bridge link control block
// What this block does
// - two-bit spread field sets link clock jitter: off, 2%, 4% or 8%.
// - four-bit rate field selects link bit rate, 1 Mbit/s up to 20 Mbit/s.
// - transmission starts only once stored words reach threshold plus one.
// - writing one to transmit flush discards every queued transmit word.
// - data ready pin goes low when receive words reach threshold plus one.
// - writing one to receive flush discards every held receive word.
// - writing one to enter bit moves device to safe state; zero changes nothing.
// - writing one to leave bit with enter bit zero returns device from safe to normal state.
// - host inactivity watchdog enters safe state after 40, 20, 10 ms or never.
package blc_pkg;
  // register indices on the serial port
  localparam logic [6:0] ADR_ID = 7'h00;
  localparam logic [6:0] ADR_HOST = 7'h01;
  localparam logic [6:0] ADR_RATE = 7'h02;
  localparam logic [6:0] ADR_TXL = 7'h03;
  localparam logic [6:0] ADR_RXL = 7'h04;
  localparam logic [6:0] ADR_SAFE = 7'h05;
  // field positions
  localparam int RATE_LSB = 0;
  localparam int SPREAD_LSB = 8;
  localparam int TXL_LSB = 0;
  localparam int RXL_LSB = 0;
  localparam int FLUSH_BIT = 15;
  localparam int ENTER_BIT = 2;
  localparam int LEAVE_BIT = 0;
  localparam int WDT_LSB = 12;
  // reset values and the watchdog off code
  localparam logic [3:0] RST_RATE = 4'h0;
  localparam logic [1:0] RST_SPREAD = 2'h0;
  localparam logic [8:0] RST_TXL = 9'h1FF;
  localparam logic [7:0] RST_RXL = 8'hFF;
  localparam logic [1:0] RST_WDT = 2'h0;
  localparam logic [1:0] WDT_OFF = 2'h3;
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int WDT_MS_A = 40;
  localparam int WDT_MS_B = 20;
  localparam int WDT_MS_C = 10;
  localparam int WDT_A_CYC = WDT_MS_A * CLK_KHZ;
  localparam int WDT_B_CYC = WDT_MS_B * CLK_KHZ;
  localparam int WDT_C_CYC = WDT_MS_C * CLK_KHZ;
  localparam int RATE_KBPS [16] = '{1000, 1250, 1430, 1670, 2000, 2220, 2500, 2860,
                                    3330, 4000, 5000, 6670, 8000, 10000, 13330, 20000};
  localparam int SPREAD_PCT [4] = '{0, 2, 4, 8};
  localparam int FRAME_LAST = 23;
  localparam int HDR_LAST = 7;
  localparam int WORD_W = 16;
  localparam int TX_DEPTH = 32;

  typedef enum logic {ST_NORMAL = 1'b0, ST_SAFE = 1'b1} blc_state_t;

  typedef struct packed {
    logic [1:0] wdt;
    logic [1:0] spread;
    logic [3:0] rate;
    logic [8:0] tx_lvl;
    logic [7:0] rx_lvl;
  } blc_cfg_t;

  // clock cycles per link bit; rounds down so the link never runs slow
  function automatic logic [7:0] rate_cycles(input logic [3:0] code);
    rate_cycles = 8'(CLK_KHZ / RATE_KBPS[code]);
  endfunction
endpackage

/* File: verification/blc_host.sv */
// host serial controller model that frames register accesses for the bridge
`timescale 1ns/1ns
module blc_host (
  input wire logic clk,
  input wire logic spi_sdo,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi
);
  // idle bus: select high, serial clock low
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  // one 24-bit frame, msb first, mode 0; half period of 8 clocks leaves room
  // for the 3-deep pin filter on every sclk edge
  task automatic xfer(input logic [23:0] frame, output logic [15:0] rdata);
    rdata = 16'h0000;
    @(negedge clk);
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_mosi = frame[i];
      repeat (8) @(negedge clk);
      spi_sclk = 1'b1;
      repeat (7) @(negedge clk);
      // read bits stand until the next filtered fall, so take them late in the high phase
      if (i <= 15) begin
        rdata[i] = spi_sdo;
      end
      @(negedge clk);
      spi_sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    spi_cs_n = 1'b1;
    // released line shows the inverse so a stale bit is never trusted
    spi_mosi = ~spi_mosi;
    repeat (6) @(negedge clk);
  endtask
endmodule // blc_host

/* File: verification/test_bridge_link_fifo_control_regs.sv */
// self-checking bench for the bridge link control registers
`timescale 1ns/1ns
module test_bridge_link_fifo_control_regs;
  localparam logic [15:0] ID_VAL = 16'h3C3C; // arbitrary identity value
  logic clk, sys_rst, spi_cs_n, spi_sclk, spi_mosi, spi_sdo, spi_sdo_oe;
  logic link_clk_in, link_clk_out, link_data_out, tx_word_valid, tx_word_ready;
  logic rx_word_taken, data_ready_pin_n, safe_state;
  logic [15:0] tx_word;
  int err_total = 0;
  int comparisons = 0;

  // short watchdog counts keep the idle test fast
  blc_regs #(.WDT_A(2000), .WDT_B(1000), .WDT_C(100), .ID_CODE(ID_VAL)) i_blc_regs (
    .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .link_clk_in(link_clk_in), .link_clk_out(link_clk_out),
    .link_data_out(link_data_out), .tx_word(tx_word), .tx_word_valid(tx_word_valid),
    .tx_word_ready(tx_word_ready), .rx_word_taken(rx_word_taken),
    .data_ready_pin_n(data_ready_pin_n), .safe_state(safe_state));
  blc_host host_m (.clk(clk), .spi_sdo(spi_sdo), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi));

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    logic [15:0] r;
    host_m.xfer({1'b1, idx, d}, r);
  endtask
  task automatic rd_chk(input logic [6:0] idx, input logic [15:0] exp);
    logic [15:0] r;
    host_m.xfer({1'b0, idx, 16'h0000}, r);
    chk_val(r, exp);
  endtask
  // one word offered for one clock; queue is known not full here
  task automatic push(input logic [15:0] w);
    @(negedge clk);
    tx_word = w;
    tx_word_valid = 1'b1;
    @(negedge clk);
    tx_word_valid = 1'b0;
  endtask
  // link clock runs only while bits arrive; 80 ns period, changed on falling edges
  task automatic link_bits(input int n);
    repeat (n) begin
      repeat (5) @(negedge clk);
      link_clk_in = 1'b1;
      repeat (5) @(negedge clk);
      link_clk_in = 1'b0;
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic meas(output int p);
    realtime t0;
    @(posedge link_clk_out);
    t0 = $realtime;
    @(posedge link_clk_out);
    p = int'(($realtime - t0) / 8.0);
  endtask

  task automatic t_reset;
    wr(7'h01, 16'h3000); // watchdog off for the long tests
    chk_bit(spi_sdo_oe, 1'b0);
    // output enable follows the select: high part way into a frame
    fork
      rd_chk(7'h01, 16'h3000);
      begin
        repeat (20) @(negedge clk);
        chk_bit(spi_sdo_oe, 1'b1);
      end
    join
    rd_chk(7'h00, ID_VAL);
    rd_chk(7'h02, 16'h0000);
    rd_chk(7'h03, 16'h01FF);
    rd_chk(7'h04, 16'h00FF);
    rd_chk(7'h05, 16'h0000);
    wr(7'h07, 16'hFFFF);
    rd_chk(7'h07, 16'h0000);
    $display("t_reset done");
  endtask

  task automatic t_rate;
    logic [3:0] codes [6] = '{4'h0, 4'h9, 4'hA, 4'hD, 4'hE, 4'hF};
    int p, lo, hi;
    for (int i = 0; i < 16; i++) begin
      wr(7'h02, {6'h00, 2'(i), 4'h0, 4'(i)});
      rd_chk(7'h02, {6'h00, 2'(i), 4'h0, 4'(i)});
    end
    foreach (codes[k]) begin
      wr(7'h02, {12'h000, codes[k]});
      meas(p);
      meas(p);
      chk_val(16'(p), 16'(blc_pkg::CLK_KHZ / blc_pkg::RATE_KBPS[codes[k]]));
    end
    // widest spread at the slowest rate: periods wander but stay in range
    wr(7'h02, 16'h0300);
    lo = 1000;
    hi = 0;
    repeat (12) begin
      meas(p);
      lo = (p < lo) ? p : lo;
      hi = (p > hi) ? p : hi;
    end
    chk_bit(lo >= 125 && hi <= 134 && hi != lo, 1'b1);
    wr(7'h02, 16'h000F);
    $display("t_rate done");
  endtask

  task automatic t_tx;
    logic [15:0] sh;
    logic seen;
    int n;
    wr(7'h03, 16'h0001);
    push(16'hA5C3);
    seen = 1'b0;
    repeat (30) begin
      @(negedge link_clk_out);
      seen = seen | link_data_out;
    end
    chk_bit(seen, 1'b0);
    push(16'h0F0F);
    n = 0;
    do begin
      @(negedge link_clk_out);
      n++;
    end while (link_data_out !== 1'b1 && n < 40);
    sh = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      sh = {sh[14:0], link_data_out};
      @(negedge link_clk_out);
    end
    chk_val(sh, 16'hA5C3);
    $display("t_tx done");
  endtask

  // fill to the refusal boundary twice; the second fill proves the flush emptied it
  task automatic t_fifo;
    wr(7'h03, 16'h01FF);
    repeat (2) begin
      repeat (31) push(16'h1234);
      chk_bit(tx_word_ready, 1'b1);
      push(16'h5678);
      chk_bit(tx_word_ready, 1'b0);
      wr(7'h03, 16'h81FF);
      chk_bit(tx_word_ready, 1'b1);
    end
    rd_chk(7'h03, 16'h01FF);
    $display("t_fifo done");
  endtask

  task automatic t_rx;
    wr(7'h04, 16'h0001);
    link_bits(16);
    chk_bit(data_ready_pin_n, 1'b1);
    link_bits(16);
    chk_bit(data_ready_pin_n, 1'b0);
    @(negedge clk);
    rx_word_taken = 1'b1;
    @(negedge clk);
    rx_word_taken = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(data_ready_pin_n, 1'b1);
    link_bits(16);
    chk_bit(data_ready_pin_n, 1'b0);
    wr(7'h04, 16'h8001);
    chk_bit(data_ready_pin_n, 1'b1);
    rd_chk(7'h04, 16'h0001);
    $display("t_rx done");
  endtask

  task automatic t_safe;
    wr(7'h05, 16'h0000);
    chk_bit(safe_state, 1'b0);
    wr(7'h05, 16'h0004);
    chk_bit(safe_state, 1'b1);
    rd_chk(7'h05, 16'h0000);
    wr(7'h05, 16'h0000);
    chk_bit(safe_state, 1'b1);
    wr(7'h05, 16'h0001);
    chk_bit(safe_state, 1'b0);
    wr(7'h05, 16'h0005);
    chk_bit(safe_state, 1'b1);
    wr(7'h05, 16'h0001);
    chk_bit(safe_state, 1'b0);
    $display("t_safe done");
  endtask

  task automatic t_wdt;
    wr(7'h01, 16'h2000);
    repeat (160) @(negedge clk);
    chk_bit(safe_state, 1'b1);
    wr(7'h01, 16'h3000);
    wr(7'h05, 16'h0001);
    repeat (160) @(negedge clk);
    chk_bit(safe_state, 1'b0);
    // slower selections: still normal just before the limit, safe just after
    wr(7'h01, 16'h1000);
    repeat (900) @(negedge clk);
    chk_bit(safe_state, 1'b0);
    repeat (200) @(negedge clk);
    chk_bit(safe_state, 1'b1);
    wr(7'h01, 16'h0000);
    wr(7'h05, 16'h0001);
    repeat (1900) @(negedge clk);
    chk_bit(safe_state, 1'b0);
    repeat (200) @(negedge clk);
    chk_bit(safe_state, 1'b1);
    $display("t_wdt done");
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    #600000;
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    link_clk_in = 1'b0;
    tx_word = 16'h0000;
    tx_word_valid = 1'b0;
    rx_word_taken = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    t_reset();
    t_rate();
    t_tx();
    t_fifo();
    t_rx();
    t_safe();
    t_wdt();
    stop_test();
  end
endmodule // test_bridge_link_fifo_control_regs
